// >>> include/tmr_pkg.sv
/*
 Package for the 16-bit timer/counter: register addresses, control bit
 positions, reset values and mode selection.
 Assumes an 8-bit special function register port with byte addresses.
*/
package tmr_pkg;
    // Special function register addresses
    localparam logic [7:0] TMR_ADDR_CTRL     = 8'hc8;
    localparam logic [7:0] TMR_ADDR_MODE     = 8'hc9;
    localparam logic [7:0] TMR_ADDR_RELOAD_L = 8'hca;
    localparam logic [7:0] TMR_ADDR_RELOAD_H = 8'hcb;
    localparam logic [7:0] TMR_ADDR_COUNT_L  = 8'hcc;
    localparam logic [7:0] TMR_ADDR_COUNT_H  = 8'hcd;
    // Control register bit positions
    localparam int TMR_BIT_OVF   = 7;
    localparam int TMR_BIT_EXF   = 6;
    localparam int TMR_BIT_RXSEL = 5;
    localparam int TMR_BIT_TXSEL = 4;
    localparam int TMR_BIT_EXEN  = 3;
    localparam int TMR_BIT_RUN   = 2;
    localparam int TMR_BIT_CNT   = 1;
    localparam int TMR_BIT_CAP   = 0;
    // Mode register bit positions
    localparam int TMR_BIT_OUTEN = 1;
    localparam int TMR_BIT_DOWN_COUNT_ENABLE  = 0;
    // Reset values and maximum count
    localparam logic [7:0]  TMR_CTRL_RST  = 8'h00;
    localparam logic [7:0]  TMR_MODE_RST  = 8'h00;
    localparam logic [15:0] TMR_WORD_RST  = 16'h0000;
    localparam logic [15:0] TMR_COUNT_MAX = 16'hffff;
    // Operating modes
    typedef enum logic [2:0] {
        TMR_OFF,
        TMR_RELOAD,
        TMR_UPDOWN,
        TMR_CAPTURE,
        TMR_BAUD,
        TMR_CLKOUT
    } tmr_mode_e;
endpackage

// >>> include/tmr_sync_if.sv
/*
 Interface carrying synchronised pin levels and their falling edges from
 the pin synchroniser to the timer core.
 Assumes both ends share the system clock.
*/
`timescale 1ns/1ns
interface tmr_sync_if;
    logic event_level;
    logic event_fall;
    logic ext_level;
    logic ext_fall;
    modport source (output event_level, output event_fall, output ext_level, output ext_fall);
    modport sink   (input  event_level, input  event_fall, input  ext_level, input  ext_fall);
endinterface

// >>> core/tmr_pin_sync.sv
/*
 Three-stage synchroniser for the event and capture/reload pins with
 falling-edge detection when the second and third stages agree low against a high accepted level.
 Assumes the pins are asynchronous to clk.
*/
`timescale 1ns/1ns
module tmr_pin_sync
    import tmr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic event_input_pin,
    input  wire logic ext_capture_reload_pin,
    tmr_sync_if.source sync
);
    typedef struct packed {
        logic [2:0] ev;
        logic [2:0] ex;
        logic       ev_lvl;
        logic       ex_lvl;
    } tmr_sync_s;

    tmr_sync_s s_q;
    tmr_sync_s s_d;

    // Shift pin samples in
    always_comb begin
        s_d    = s_q;
        s_d.ev = {s_q.ev[1:0], event_input_pin};
        s_d.ex = {s_q.ex[1:0], ext_capture_reload_pin};
        // Accepted level moves only when stages two and three agree
        if (s_q.ev[2] == s_q.ev[1]) begin
            s_d.ev_lvl = s_q.ev[2];
        end
        if (s_q.ex[2] == s_q.ex[1]) begin
            s_d.ex_lvl = s_q.ex[2];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // Fall seen when agreed low follows an accepted high
    assign sync.event_level = s_q.ev_lvl;
    assign sync.event_fall  = s_q.ev_lvl & ~s_q.ev[2] & ~s_q.ev[1];
    assign sync.ext_level   = s_q.ex_lvl;
    assign sync.ext_fall    = s_q.ex_lvl & ~s_q.ex[2] & ~s_q.ex[1];
endmodule // tmr_pin_sync

// >>> core/tmr_timer.sv
/*
 16-bit timer/counter with capture, auto-reload (up/down), baud clock and
 clock-out modes, reached through the special function register port.
 Assumes single-cycle register writes and a combinational read port;
 the serial port consumes the baud pulses in its modes 1 and 3.
*/
`timescale 1ns/1ns
//
// Operation
// - Count readable at high and low addresses
// - Capture/reload value at its two addresses
// - Control register bits in documented order
// - External falling edge sets external flag (here only in capture or reload mode)
// - External flag requests interrupt when enabled
// - External flag cleared only by software
// - No external interrupt in up/down mode
// - Receive select routes overflow to receiver
// - Otherwise receiver uses other timer overflow
// - Capture, reload, baud modes with priority
// - Counter mode counts event pin falls (here not in baud or clock-out mode, which count every clock)
// - Capture count on external falling edge
module tmr_timer
    import tmr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_we,
    output logic      [7:0] sfr_rdata,
    input  wire logic       event_input_pin,
    input  wire logic       ext_capture_reload_pin,
    input  wire logic       other_timer_overflow,
    input  wire logic       timer_irq_enable,
    output logic            timer_irq,
    output logic            rx_baud_tick,
    output logic            tx_baud_tick,
    output logic            event_pin_out,
    output logic            event_pin_oe
);
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  mode;
        logic [15:0] count;
        logic [15:0] reload;
        logic        clk_out;
        logic        ovf_tick;
    } tmr_state_s;

    tmr_state_s s_q;
    tmr_state_s s_d;
    tmr_sync_if sync ();
    tmr_mode_e  op;
    logic       run;
    logic       baud_sel;
    logic       step;
    logic       down;
    logic       ext_hit;
    logic       wrap;

    tmr_pin_sync u_sync (
        .clk                    (clk),
        .rstn                   (rstn),
        .event_input_pin        (event_input_pin),
        .ext_capture_reload_pin (ext_capture_reload_pin),
        .sync                   (sync.source)
    );

    // Mode decode: baud and clock-out win over capture select
    always_comb begin
        run      = s_q.ctrl[TMR_BIT_RUN];
        baud_sel = s_q.ctrl[TMR_BIT_RXSEL] | s_q.ctrl[TMR_BIT_TXSEL];
        if (!run) begin
            op = TMR_OFF;
        end else if (baud_sel) begin
            op = TMR_BAUD;
        end else if (s_q.mode[TMR_BIT_OUTEN]) begin
            op = TMR_CLKOUT;
        end else if (s_q.ctrl[TMR_BIT_CAP]) begin
            op = TMR_CAPTURE;
        end else if (s_q.mode[TMR_BIT_DOWN_COUNT_ENABLE]) begin
            op = TMR_UPDOWN;
        end else begin
            op = TMR_RELOAD;
        end
    end

    // Count step source, direction and terminal detection
    always_comb begin
        ext_hit = sync.ext_fall & s_q.ctrl[TMR_BIT_EXEN];
        if (s_q.ctrl[TMR_BIT_CNT] && op != TMR_CLKOUT && op != TMR_BAUD) begin
            step = run & sync.event_fall;
        end else begin
            step = run;
        end
        // Direction follows capture/reload pin level in up/down mode with the external enable bit set
        down = (op == TMR_UPDOWN) & s_q.ctrl[TMR_BIT_EXEN] & ~sync.ext_level;
        if (down) begin
            wrap = step & (s_q.count == s_q.reload);
        end else begin
            wrap = step & (s_q.count == TMR_COUNT_MAX);
        end
    end

    // Next state: counting, capture, reload, flags and register writes
    always_comb begin
        s_d          = s_q;
        s_d.ovf_tick = 1'b0;
        if (step) begin
            if (down) begin
                s_d.count = wrap ? TMR_COUNT_MAX : s_q.count - 16'h0001;
            end else if (wrap && op != TMR_CAPTURE) begin
                s_d.count = s_q.reload;
            end else begin
                s_d.count = s_q.count + 16'h0001;
            end
        end
        if (wrap) begin
            s_d.ovf_tick = 1'b1;
            if (op == TMR_CLKOUT) begin
                s_d.clk_out = ~s_q.clk_out;
            end
        end
        // External edge: capture or forced reload
        if (ext_hit && run) begin
            if (op == TMR_CAPTURE) begin
                s_d.reload = s_q.count;
            end else if (op == TMR_RELOAD) begin
                s_d.count = s_q.reload;
            end
        end
        // Software writes, hardware set below wins
        if (sfr_we) begin
            case (sfr_addr)
                TMR_ADDR_CTRL:     s_d.ctrl          = sfr_wdata;
                TMR_ADDR_MODE:     s_d.mode          = {6'h00, sfr_wdata[1:0]};
                TMR_ADDR_RELOAD_L: s_d.reload[7:0]   = sfr_wdata;
                TMR_ADDR_RELOAD_H: s_d.reload[15:8]  = sfr_wdata;
                TMR_ADDR_COUNT_L:  s_d.count[7:0]    = sfr_wdata;
                TMR_ADDR_COUNT_H:  s_d.count[15:8]   = sfr_wdata;
                default: ;
            endcase
        end
        // Overflow flag not set while a baud source is selected
        if (wrap && !baud_sel) begin
            s_d.ctrl[TMR_BIT_OVF] = 1'b1;
        end
        // External flag set on enabled edge in capture or reload mode; never cleared by hardware
        if (ext_hit && run && (op == TMR_CAPTURE || op == TMR_RELOAD)) begin
            s_d.ctrl[TMR_BIT_EXF] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{ctrl: TMR_CTRL_RST, mode: TMR_MODE_RST, count: TMR_WORD_RST,
                     reload: TMR_WORD_RST, clk_out: 1'b0, ovf_tick: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // Register read multiplexer
    always_comb begin
        case (sfr_addr)
            TMR_ADDR_CTRL:     sfr_rdata = s_q.ctrl;
            TMR_ADDR_MODE:     sfr_rdata = s_q.mode;
            TMR_ADDR_RELOAD_L: sfr_rdata = s_q.reload[7:0];
            TMR_ADDR_RELOAD_H: sfr_rdata = s_q.reload[15:8];
            TMR_ADDR_COUNT_L:  sfr_rdata = s_q.count[7:0];
            TMR_ADDR_COUNT_H:  sfr_rdata = s_q.count[15:8];
            default:           sfr_rdata = 8'h00;
        endcase
    end

    // Interrupt request, external flag masked in up/down operation
    assign timer_irq = timer_irq_enable & (s_q.ctrl[TMR_BIT_OVF] |
                       (s_q.ctrl[TMR_BIT_EXF] & ~s_q.mode[TMR_BIT_DOWN_COUNT_ENABLE]));

    // Baud clock sources for the serial port
    assign rx_baud_tick = s_q.ctrl[TMR_BIT_RXSEL] ? s_q.ovf_tick : other_timer_overflow;
    assign tx_baud_tick = s_q.ctrl[TMR_BIT_TXSEL] ? s_q.ovf_tick : other_timer_overflow;

    // Clock-out toggle drives the event pin when timer function selected
    assign event_pin_out = s_q.clk_out;
    assign event_pin_oe  = s_q.mode[TMR_BIT_OUTEN] & ~s_q.ctrl[TMR_BIT_CNT];
endmodule // tmr_timer

// >>> tb/tmr_checker.sv
/* Concurrent checks on the timer register port, flags and baud ticks.
   Bound to tmr_timer; sees only its ports, on the system clock. */
`timescale 1ns/1ns
module tmr_checker (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_we,
    input wire logic [7:0] sfr_rdata,
    input wire logic       other_timer_overflow,
    input wire logic       timer_irq_enable,
    input wire logic       timer_irq,
    input wire logic       rx_baud_tick,
    input wire logic       tx_baud_tick
);
    // One clock domain, reset disables all
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Control register on the read port
    logic rd_ctrl;
    assign rd_ctrl = (sfr_addr == 8'hc8);
    chk_unmapped_zero: assert property ((sfr_addr < 8'hc8 || sfr_addr > 8'hcd) |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_ctrl_write: assert property (sfr_we && rd_ctrl ##1 rd_ctrl |-> sfr_rdata[5:0] == $past(sfr_wdata[5:0]))
        else $error("control bits not as written");
    chk_ext_sticky: assert property ((rd_ctrl && sfr_rdata[6] && !sfr_we) ##1 rd_ctrl |-> sfr_rdata[6])
        else $error("external flag cleared by hardware");
    chk_ovf_baud: assert property ((rd_ctrl && |sfr_rdata[5:4] && !sfr_rdata[7] && !sfr_we) ##1 rd_ctrl |-> !sfr_rdata[7])
        else $error("overflow flag set in baud mode");
    chk_rx_other: assert property (rd_ctrl && !sfr_rdata[5] |-> rx_baud_tick == other_timer_overflow)
        else $error("rx tick not from other timer");
    chk_tx_other: assert property (rd_ctrl && !sfr_rdata[4] |-> tx_baud_tick == other_timer_overflow)
        else $error("tx tick not from other timer");
    chk_irq_masked: assert property (!timer_irq_enable |-> !timer_irq)
        else $error("irq while disabled");
    chk_ovf_irq: assert property (rd_ctrl && sfr_rdata[7] && timer_irq_enable |-> timer_irq)
        else $error("overflow flag without irq");
endmodule // tmr_checker

bind tmr_timer tmr_checker tmr_checker_inst (.clk, .rstn, .sfr_addr, .sfr_wdata, .sfr_we, .sfr_rdata,
    .other_timer_overflow, .timer_irq_enable, .timer_irq, .rx_baud_tick, .tx_baud_tick);

// >>> tb/tb.sv
/* Self-checking bench for tmr_timer: registers, counting, flags, capture.
   Assumes a 50 MHz clock and inputs driven 2 ns after each edge. */
`timescale 1ns/1ns
module tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  sfr_addr = 8'hc8;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_we = 1'b0;
    logic [7:0]  sfr_rdata;
    logic        event_input_pin = 1'b1;
    logic        ext_capture_reload_pin = 1'b1;
    logic        other_timer_overflow = 1'b0;
    logic        timer_irq_enable = 1'b1;
    logic        timer_irq;
    logic        rx_baud_tick;
    logic        tx_baud_tick;
    logic        event_pin_out;
    logic        event_pin_oe;
    logic        seen;
    logic [15:0] lfsr_q = 16'hce50;
    logic [15:0] val;
    int          errors = 0;
    int          samples_checked = 0;
    // Clock
    always #10 clk = ~clk;
    tmr_timer tmr_timer_inst (.clk, .rstn, .sfr_addr, .sfr_wdata, .sfr_we, .sfr_rdata, .event_input_pin,
        .ext_capture_reload_pin, .other_timer_overflow, .timer_irq_enable, .timer_irq, .rx_baud_tick,
        .tx_baud_tick, .event_pin_out, .event_pin_oe);
    // Random other-timer overflow pulses
    always @(posedge clk) begin
        #2;
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        other_timer_overflow = lfsr_q[0];
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_we = 1'b1;
        @(posedge clk) #2;
        sfr_we = 1'b0;
        sfr_addr = 8'hc8;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        #1;
        chk(sfr_rdata, exp);
        sfr_addr = 8'hc8;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        test_done();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        #2 rstn = 1'b1;
        for (int a = 8'hc7; a <= 8'hce; a++) rd(8'(a), 8'h00);
        $display("test reset done");
        val = lfsr_q;
        wr(8'hca, val[7:0]);
        wr(8'hcb, val[15:8]);
        wr(8'hc8, 8'h38);
        rd(8'hca, val[7:0]);
        rd(8'hcb, val[15:8]);
        rd(8'hc8, 8'h38);
        $display("test registers done");
        wr(8'hcc, 8'hf0);
        wr(8'hcd, 8'h00);
        wr(8'hc8, 8'h04);
        idle(19);
        wr(8'hc8, 8'h00);
        idle(3);
        val = 16'h00f0 + 16'd20;
        rd(8'hcc, val[7:0]);
        rd(8'hcd, val[15:8]);
        $display("test run done");
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h04);
        idle(4);
        rd(8'hc8, 8'h84);
        chk({7'h00, timer_irq}, 8'h01);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h34);
        seen = 1'b0;
        repeat (300) begin
            @(posedge clk) #1 seen = seen | (rx_baud_tick & tx_baud_tick);
        end
        #1;
        chk({7'h00, seen}, 8'h01);
        rd(8'hc8, 8'h34);
        wr(8'hc8, 8'h00);
        $display("test overflow done");
        val = lfsr_q;
        wr(8'hcc, val[7:0]);
        wr(8'hcd, val[15:8]);
        wr(8'hc8, 8'h0f);
        ext_capture_reload_pin = 1'b0;
        idle(5);
        ext_capture_reload_pin = 1'b1;
        rd(8'hca, val[7:0]);
        rd(8'hcb, val[15:8]);
        rd(8'hc8, 8'h4f);
        chk({7'h00, timer_irq}, 8'h01);
        idle(20);
        rd(8'hc8, 8'h4f);
        wr(8'hc8, 8'h0f);
        rd(8'hc8, 8'h0f);
        $display("test capture done");
        wr(8'hc9, 8'h01);
        wr(8'hc8, 8'h40);
        chk({7'h00, timer_irq}, 8'h00);
        wr(8'hc9, 8'h00);
        chk({7'h00, timer_irq}, 8'h01);
        wr(8'hc9, 8'h02);
        chk({7'h00, event_pin_oe}, 8'h01);
        wr(8'hc9, 8'h00);
        chk({7'h00, event_pin_oe}, 8'h00);
        $display("test masking done");
        wr(8'hcc, 8'h00);
        wr(8'hcd, 8'h00);
        wr(8'hc8, 8'h06);
        repeat (5) begin
            event_input_pin = 1'b0;
            idle(2);
            event_input_pin = 1'b1;
            idle(2);
        end
        idle(4);
        wr(8'hc8, 8'h00);
        rd(8'hcc, 8'h05);
        $display("test counter done");
        test_done();
    end
endmodule // tb
